// >>> hw/dpmb_host.sv
`timescale 1ns/1ps
module dpmb_host
  import dpmb_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // Request side
  input  wire dpmb_pkg::dpmb_req_type req,
  input  wire logic                   reqValid,
  output logic                        reqReady,
  output logic                        done,
  output logic                        lostArb,
  output logic [8:0]                  rdata,
  // Device port pins
  output dpmb_pkg::dpmb_pins_type     pins,
  input  wire logic [8:0]             dataIn,
  output logic [8:0]                  dataOut,
  output logic                        dataOe,
  input  wire logic                   busyN,
  input  wire logic                   mailIntN,
  // Status
  output logic                        mailPending
);
  import dpmb_pkg::*;

  typedef enum logic [5:0] {
    S_IDLE   = 6'h01,
    S_SETUP  = 6'h02,
    S_SETTLE = 6'h04,
    S_PULSE  = 6'h08,
    S_HOLD   = 6'h10,
    S_DONE   = 6'h20
  } dpmb_state_type;

  dpmb_state_type state;
  dpmb_req_type   cur;
  dpmb_pins_type  next_pins;
  logic [7:0]     cnt;
  logic           capture;
  logic           take;
  logic           cntZero;
  logic           selPhase;
  logic           pulseStart;
  logic           writeGate;

  // Read data register
  dpmb_rdbuf #(.W(9)) dpmb_rdbuf_i (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (capture),
    .din     (dataIn),
    .dout    (rdata)
  );

  // Phase decode shared by sequencer and pin drive
  assign take       = reqValid && reqReady;
  assign cntZero    = (cnt == 8'h00);
  assign selPhase   = (state == S_SETTLE) || (state == S_PULSE);
  assign pulseStart = (state == S_PULSE) && (cnt == 8'(PULSE_CYC));
  assign capture    = (state == S_PULSE) && !cur.write && cntZero;
  // Busy low holds rw high; slave follows master outcome
  assign writeGate  = cur.write && (state == S_PULSE) && busyN;

  // Request latch, loaded on the accepting edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur <= '0;
    end else if (take) begin
      cur <= req;
    end
  end

  // Sequencer: address stable with rw high, then select, then pulse
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state <= S_IDLE;
      cnt   <= 8'h00;
    end else begin
      case (state)
        S_IDLE: begin
          if (take) begin
            cnt   <= 8'(SETUP_CYC - 1);
            state <= S_SETUP;  // address moves while rw high
          end
        end
        S_SETUP: begin
          if (cntZero) begin
            cnt   <= 8'(SETTLE - 1);
            state <= S_SETTLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        S_SETTLE: begin
          // Let busy settle and flowthrough pass before acting
          if (cntZero) begin
            cnt   <= 8'(PULSE_CYC);
            state <= S_PULSE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        S_PULSE: begin
          if (cntZero) begin
            cnt   <= 8'(HOLD_CYC - 1);
            state <= S_HOLD;  // rw and select rise together, ending write
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        S_HOLD: begin
          if (cntZero) begin
            state <= S_DONE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        S_DONE: begin
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Ready only while idle, dropped on the accepting edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reqReady <= 1'b0;
    end else begin
      reqReady <= (state == S_IDLE) && !take;
    end
  end

  // One-cycle completion strobe
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      done <= 1'b0;
    end else begin
      done <= (state == S_DONE);
    end
  end

  // Arbitration outcome, sampled once select has been low a cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lostArb <= 1'b0;
    end else if (pulseStart) begin
      lostArb <= !busyN;  // busy low: other port won
    end
  end

  // Next pin levels from phase and request kind
  always_comb begin
    next_pins      = pins;
    next_pins.addr = (state == S_IDLE) ? pins.addr : cur.addr;
    // Select low from settle to pulse end; never both selects
    next_pins.selN      = !(!cur.token && selPhase);
    next_pins.tokenSelN = !(cur.token && selPhase);
    // rw low only inside pulse, after select, so outputs stay off
    next_pins.rwN = !writeGate;
    // Output enable only for reads
    next_pins.oeN = !(!cur.write && selPhase);
  end

  // Pin register, idle levels under reset
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pins <= '{selN: 1'b1, tokenSelN: 1'b1, rwN: 1'b1, oeN: 1'b1, addr: '0};
    end else begin
      pins <= next_pins;
    end
  end

  // Write data drive; token writes carry bit 0 only
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dataOut <= '0;
      dataOe  <= 1'b0;
    end else begin
      dataOut <= cur.token ? {8'h00, cur.wdata[0]} : cur.wdata;
      dataOe  <= cur.write && selPhase;
    end
  end

  // Mailbox interrupt seen from this port
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mailPending <= 1'b0;
    end else begin
      mailPending <= !mailIntN;
    end
  end
endmodule // dpmb_host

// >>> hw/dpmb_pkg.sv
package dpmb_pkg;
  // Geometry
  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 9;
  localparam logic [14:0] MBOX_RIGHT = 15'h7FFF;
  localparam logic [14:0] MBOX_LEFT  = 15'h7FFE;
  // Timing in ns, at 50 MHz
  localparam int CLK_NS        = 20;
  localparam int SETUP_NS      = 15; // address/select set-up before write pulse
  localparam int PULSE_NS      = 15; // write or read pulse width
  localparam int BUSY_SETTLE_NS = 20; // busy settle after select
  localparam int FLOW_NS       = 30; // flowthrough_delay
  localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = (BUSY_SETTLE_NS + FLOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC   = 1;

  // Host request
  typedef struct packed {
    logic        write;
    logic        token;  // access semaphore latch instead of array
    logic [14:0] addr;
    logic [8:0]  wdata;
  } dpmb_req_type;

  // Pins toward one device port
  typedef struct packed {
    logic        selN;
    logic        tokenSelN;
    logic        rwN;
    logic        oeN;
    logic [14:0] addr;
  } dpmb_pins_type;
endpackage

// >>> hw/dpmb_rdbuf.sv
`timescale 1ns/1ps
// Small registered read-data holder
module dpmb_rdbuf #(
  parameter int W = 9
) (
  // Clock
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // Capture
  input  wire logic         load,
  input  wire logic [W-1:0] din,
  // Result
  output logic [W-1:0]      dout
);
  // Capture on load
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dout <= '0;
    end else if (load) begin
      dout <= din;
    end
  end
endmodule // dpmb_rdbuf

// >>> tb/dpmb_host_properties.sv
`timescale 1ns/1ps
module dpmb_host_properties (
  // Watched ports
  input wire logic                    ref_clk,
  input wire logic                    rstn,
  input wire dpmb_pkg::dpmb_pins_type pins,
  input wire logic                    dataOe,
  input wire logic                    busyN,
  input wire logic                    mailIntN,
  input wire logic                    mailPending,
  input wire logic                    done,
  input wire logic                    reqValid,
  input wire logic                    reqReady
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  both_sel_a: assert property (pins.selN || pins.tokenSelN) else $error("both selects low");
  rw_addr_a: assert property ($changed(pins.addr) |-> pins.rwN && $past(pins.rwN))
    else $error("address moved in write");
  write_sel_a: assert property (!pins.rwN |-> !pins.selN || !pins.tokenSelN)
    else $error("write without select");
  oe_drive_a: assert property (!pins.oeN |-> !dataOe) else $error("bus fight on read");
  busy_block_a: assert property (!busyN |-> pins.rwN) else $error("write under busy");
  done_pulse_a: assert property (done |=> !done) else $error("done too long");
  take_a: assert property (reqValid && reqReady |=> !reqReady) else $error("ready after take");
  idle_a: assert property (reqReady |-> pins.selN && pins.tokenSelN)
    else $error("selected while idle");
  mirror_a: assert property ($past(rstn) |-> mailPending == !$past(mailIntN))
    else $error("pending flag wrong");
endmodule // dpmb_host_properties

bind dpmb_host dpmb_host_properties dpmb_host_properties_i (.ref_clk(ref_clk), .rstn(rstn),
  .pins(pins), .dataOe(dataOe), .busyN(busyN), .mailIntN(mailIntN), .mailPending(mailPending),
  .done(done), .reqValid(reqValid), .reqReady(reqReady));

// >>> tb/dpmb_port_model.sv
`timescale 1ns/1ps
module dpmb_port_model (
  // Port pins
  input  wire dpmb_pkg::dpmb_pins_type pins,
  input  wire logic [8:0]              dataOut,
  output logic [8:0]                   dataIn,
  output logic                         busyN,
  output logic                         mailIntN,
  // Far port stand-ins
  input  wire logic                    contend,
  input  wire logic                    otherMail
);
  import dpmb_pkg::*;
  logic [8:0] mem [32768];
  logic [8:0] token = 9'h1FF;
  logic [8:0] junk  = 9'h155;
  logic       farIntN = 1'h1; // far port's interrupt, active low
  wire memRd = !pins.selN && pins.rwN && !pins.oeN;
  wire tokRd = !pins.tokenSelN && pins.rwN && !pins.oeN;
  wire memWr = !pins.selN && !pins.rwN && busyN;
  wire tokWr = !pins.tokenSelN && !pins.rwN;
  initial mailIntN = 1'h1;
  // Loser sees busy while selected
  assign busyN = !(contend && !pins.selN);
  // Released bus shows a moving pattern
  always #10 junk = ~junk;
  assign dataIn = memRd ? mem[pins.addr] : tokRd ? token : junk;
  // Store when the low overlap ends
  always @(negedge memWr) mem[pins.addr] = dataOut;
  always @(negedge tokWr) token = {9{dataOut[0]}};
  // Far mailbox write raises far interrupt, never under busy
  always @(negedge memWr) if (pins.addr == MBOX_RIGHT) farIntN = 1'h0;
  // Mailbox flag set from far side, cleared by own read
  always @(posedge otherMail or posedge memRd)
    if (otherMail) mailIntN = 1'h0;
    // Selected here, so busy is just contend; avoids update-order race
    else if (pins.addr == MBOX_LEFT && !contend) mailIntN = 1'h1;
endmodule // dpmb_port_model

// >>> tb/tb_dpmb_host.sv
`timescale 1ns/1ps
module tb_dpmb_host;
  import dpmb_pkg::*;
  logic ref_clk = 0, rstn = 0, reqValid = 0, contend = 0, otherMail = 0;
  logic reqReady, done, lostArb, dataOe, busyN, mailIntN, mailPending;
  logic [8:0] rdata, dataIn, dataOut, d;
  logic [14:0] a;
  logic [10:0] e, q[$];
  dpmb_req_type req = '0;
  dpmb_pins_type pins;
  int n_errors = 0, n_tests = 0, seed;
  dpmb_host #(.SETTLE(1)) dpmb_host_i (.ref_clk(ref_clk), .rstn(rstn), .req(req),
    .reqValid(reqValid), .reqReady(reqReady), .done(done), .lostArb(lostArb), .rdata(rdata),
    .pins(pins), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .busyN(busyN),
    .mailIntN(mailIntN), .mailPending(mailPending));
  dpmb_port_model dpmb_port_model_i (.pins(pins), .dataOut(dataOut), .dataIn(dataIn),
    .busyN(busyN), .mailIntN(mailIntN), .contend(contend), .otherMail(otherMail));
  always #10 ref_clk = ~ref_clk;
  task automatic cmp(input logic [9:0] x, input logic [9:0] g);
    n_tests++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch result exp %h seen %h", x, g);
    end
  endtask
  task automatic conclude;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Note {read, lost, data}, then run one access
  task automatic acc(input logic w, t, input logic [14:0] ad, input logic [8:0] wd,
                     input logic [10:0] x);
    q.push_back(x);
    req <= '{w, t, ad, wd};
    reqValid <= 1'h1;
    do @(posedge ref_clk); while (reqReady !== 1'h1);
    reqValid <= 1'h0;
    do @(posedge ref_clk); while (done !== 1'h1);
  endtask
  // Scoreboard on each finished access
  always @(posedge ref_clk) if (done === 1'h1) begin
    e = q.pop_front();
    cmp(e[9:0], {lostArb, e[10] ? rdata : e[8:0]});
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    conclude();
  end
  initial begin
    seed = 32'h082ba765;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      a = $random(seed);
      a[14] = 1'h0;
      d = $random(seed);
      acc(1'h1, 1'h0, a, d, {2'h0, d});
      acc(1'h0, 1'h0, a, 9'h000, {2'h2, d});
    end
    $display("array test done");
    acc(1'h1, 1'h0, MBOX_LEFT, 9'h0A5, 11'h000);
    acc(1'h1, 1'h0, 15'h0000, 9'h033, 11'h000);
    otherMail <= 1'h1;
    @(posedge ref_clk);
    otherMail <= 1'h0;
    contend <= 1'h1;
    repeat (2) @(posedge ref_clk);
    cmp(10'h001, {9'h000, mailPending});
    acc(1'h0, 1'h0, MBOX_LEFT, 9'h000, 11'h6A5);
    acc(1'h1, 1'h0, 15'h0000, 9'h1FF, 11'h200);
    acc(1'h1, 1'h0, MBOX_RIGHT, 9'h0FF, 11'h200);
    cmp(10'h001, {9'h000, dpmb_port_model_i.farIntN});
    contend <= 1'h0;
    acc(1'h1, 1'h0, MBOX_RIGHT, 9'h15A, 11'h000);
    cmp(10'h000, {9'h000, dpmb_port_model_i.farIntN});
    acc(1'h0, 1'h0, 15'h0000, 9'h000, 11'h433);
    acc(1'h0, 1'h0, MBOX_RIGHT, 9'h000, 11'h55A);
    cmp(10'h001, {9'h000, mailPending});
    acc(1'h0, 1'h0, MBOX_LEFT, 9'h000, 11'h4A5);
    cmp(10'h000, {9'h000, mailPending});
    $display("mailbox test done");
    acc(1'h1, 1'h1, 15'h0000, 9'h000, 11'h000);
    acc(1'h0, 1'h1, 15'h0000, 9'h000, 11'h400);
    acc(1'h1, 1'h1, 15'h0000, 9'h001, 11'h000);
    acc(1'h0, 1'h1, 15'h0000, 9'h000, 11'h5FF);
    $display("token test done");
    @(posedge ref_clk);
    conclude();
  end
endmodule // tb_dpmb_host
